/* hw/asrc_ctrl.sv */
`timescale 1ns/100ps
module asrc_ctrl
   import asrc_pkg::*;
#(
   parameter int WP_CYCLES = WP_CYC,
   parameter int ACC_CYCLES = ACC_CYC
) (
   // clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // user request
   input wire logic REQ,
   input wire logic REQ_WRITE,
   input wire logic [asrc_pkg::ADDR_W-1:0] REQ_ADDR,
   input wire logic [asrc_pkg::DATA_W-1:0] REQ_WDATA,
   output logic REQ_READY,
   output logic RD_VALID,
   output logic [asrc_pkg::DATA_W-1:0] RD_DATA,
   // memory pins
   output logic [asrc_pkg::ADDR_W-1:0] WORD_ADDRESS,
   output logic CHIP_SELECT_N,
   output logic WRITE_ENABLE_N,
   output logic OUTPUT_ENABLE_N,
   input wire logic [asrc_pkg::DATA_W-1:0] SHARED_DATA_LINES_I,
   output logic [asrc_pkg::DATA_W-1:0] SHARED_DATA_LINES_O,
   output logic SHARED_DATA_LINES_OE_N
);
   import asrc_pkg::*;

   asrc_state_t state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] wdat_q, wdat_d;
   logic cs_n_q, cs_n_d;
   logic we_n_q, we_n_d;
   logic oe_n_q, oe_n_d;
   logic doe_n_q, doe_n_d;
   logic rdy_q, rdy_d;
   logic rv_q, rv_d;
   logic [DATA_W-1:0] rdat_q, rdat_d;
   logic [DATA_W-1:0] din_s;

   // data pins are asynchronous to CLK; sampled only after access time
   asrc_sync #(.W(DATA_W)) u_sync (
      .clk(CLK),
      .nrst(NRST),
      .d(SHARED_DATA_LINES_I),
      .q(din_s)
   );

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      cs_n_d = cs_n_q;
      we_n_d = we_n_q;
      oe_n_d = oe_n_q;
      doe_n_d = doe_n_q;
      rdy_d = rdy_q;
      unique case (state_q)
         ASRC_IDLE: begin
            if (REQ && rdy_q) begin
               rdy_d = 1'b0;
               cs_n_d = 1'b0;
               if (REQ_WRITE) begin
                  oe_n_d = 1'b1;
                  doe_n_d = 1'b0;
                  state_d = ASRC_WSET;
               end else begin
                  we_n_d = 1'b1;
                  doe_n_d = 1'b1;
                  state_d = ASRC_RACC;
                  cnt_d = CNT_W'(ACC_CYCLES);
               end
            end
         end
         ASRC_WSET: begin
            // chip select already low, so the write starts on this fall
            we_n_d = 1'b0;
            cnt_d = CNT_W'(WP_CYCLES);
            state_d = ASRC_WPULSE;
         end
         ASRC_WPULSE: begin
            // address and data frozen during the overlap
            if (cnt_q <= CNT_W'(1)) begin
               we_n_d = 1'b1;
               state_d = ASRC_WEND;
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         ASRC_WEND: begin
            // data and address held one cycle past write end
            cs_n_d = 1'b1;
            doe_n_d = 1'b1;
            rdy_d = 1'b1;
            state_d = ASRC_IDLE;
         end
         ASRC_RACC: begin
            oe_n_d = 1'b0;
            // two extra cycles absorb the synchroniser
            if (cnt_q == '0) begin
               cnt_d = CNT_W'(2);
               state_d = ASRC_RCAP;
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         ASRC_RCAP: begin
            if (cnt_q <= CNT_W'(1)) begin
               cs_n_d = 1'b1;
               oe_n_d = 1'b1;
               state_d = ASRC_RFLOAT;
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         ASRC_RFLOAT: begin
            // bus turnaround: memory floats before we may drive again
            rdy_d = 1'b1;
            state_d = ASRC_IDLE;
         end
         default: begin
            state_d = ASRC_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state_q <= ASRC_IDLE;
         cnt_q <= '0;
         cs_n_q <= 1'b1;
         we_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         doe_n_q <= 1'b1;
         rdy_q <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cs_n_q <= cs_n_d;
         we_n_q <= we_n_d;
         oe_n_q <= oe_n_d;
         doe_n_q <= doe_n_d;
         rdy_q <= rdy_d;
      end
   end

   // address and data change only on an accepted request
   always_comb begin
      addr_d = addr_q;
      wdat_d = wdat_q;
      if (state_q == ASRC_IDLE && REQ && rdy_q) begin
         // set on the edge chip select falls, one cycle before write or output enable falls
         addr_d = REQ_ADDR;
         wdat_d = REQ_WDATA;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         addr_q <= '0;
         wdat_q <= '0;
      end else begin
         addr_q <= addr_d;
         wdat_q <= wdat_d;
      end
   end

   // capture once the synchroniser has settled the data pins
   always_comb begin
      rv_d = 1'b0;
      rdat_d = rdat_q;
      if (state_q == ASRC_RCAP && cnt_q <= CNT_W'(1)) begin
         rdat_d = din_s;
         rv_d = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rv_q <= 1'b0;
         rdat_q <= '0;
      end else begin
         rv_q <= rv_d;
         rdat_q <= rdat_d;
      end
   end

   always_comb begin
      WORD_ADDRESS = addr_q;
      CHIP_SELECT_N = cs_n_q;
      WRITE_ENABLE_N = we_n_q;
      OUTPUT_ENABLE_N = oe_n_q;
      SHARED_DATA_LINES_O = wdat_q;
      SHARED_DATA_LINES_OE_N = doe_n_q;
      REQ_READY = rdy_q;
      RD_VALID = rv_q;
      RD_DATA = rdat_q;
   end
endmodule : asrc_ctrl

/* hw/asrc_pkg.sv */
package asrc_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int DEPTH = 524288;
   localparam int CLK_PERIOD_NS = 10;
   // write strobe overlap minimums, output enable held high during writes
   localparam int T_WP_NS = 7;
   localparam int T_CW_NS = 7;
   localparam int T_AW_NS = 7;
   localparam int T_DW_NS = 5;
   localparam int T_WR_NS = 0;
   localparam int T_DH_NS = 0;
   localparam int T_RC_NS = 10;
   localparam int T_WC_NS = 10;
   localparam int T_AA_NS = 10;
   localparam int T_CO_NS = 10;
   localparam int T_HZ_NS = 5;
   localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACC_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HZ_CYC = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;
   typedef enum logic [2:0] {
      ASRC_IDLE, ASRC_WSET, ASRC_WPULSE, ASRC_WEND,
      ASRC_RACC, ASRC_RCAP, ASRC_RFLOAT
   } asrc_state_t;
endpackage : asrc_pkg

/* hw/asrc_sync.sv */
`timescale 1ns/100ps
module asrc_sync #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s1_d;
   logic [W-1:0] q_d;

   always_comb begin
      s1_d = d;
      q_d = s1_q;
   end

   // first stage feeds only the second
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_q <= '0;
         q <= '0;
      end else begin
         s1_q <= s1_d;
         q <= q_d;
      end
   end
endmodule : asrc_sync

/* sim/asrc_ctrl_monitor.sv */
`timescale 1ns/100ps
module asrc_monitor
   import asrc_pkg::*;
#(parameter int WP_CYCLES = 1, parameter int ACC_CYCLES = 1) (
   // watched ports
   input wire logic CLK,
   input wire logic NRST,
   input wire logic REQ,
   input wire logic REQ_WRITE,
   input wire logic [asrc_pkg::ADDR_W-1:0] REQ_ADDR,
   input wire logic [asrc_pkg::DATA_W-1:0] REQ_WDATA,
   input wire logic REQ_READY,
   input wire logic RD_VALID,
   input wire logic [asrc_pkg::ADDR_W-1:0] WORD_ADDRESS,
   input wire logic CHIP_SELECT_N,
   input wire logic WRITE_ENABLE_N,
   input wire logic OUTPUT_ENABLE_N,
   input wire logic [asrc_pkg::DATA_W-1:0] SHARED_DATA_LINES_O,
   input wire logic SHARED_DATA_LINES_OE_N
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   chk_read_we_high: assert property (
      !OUTPUT_ENABLE_N |-> WRITE_ENABLE_N)
      else $error("write enable low while reading");
   chk_no_contention: assert property (
      !OUTPUT_ENABLE_N |-> SHARED_DATA_LINES_OE_N)
      else $error("data driven while memory outputs on");
   chk_pulse_shape: assert property (
      $fell(WRITE_ENABLE_N) |-> OUTPUT_ENABLE_N
      ##1 (WRITE_ENABLE_N && !CHIP_SELECT_N))
      else $error("write pulse shape wrong");
   chk_addr_setup: assert property (
      $fell(WRITE_ENABLE_N) |-> (!$past(CHIP_SELECT_N)
      && $stable(WORD_ADDRESS)))
      else $error("address not set before write");
   chk_data_hold: assert property (
      (!WRITE_ENABLE_N && !CHIP_SELECT_N) |=> ($stable(WORD_ADDRESS)
      && $stable(SHARED_DATA_LINES_O) && !SHARED_DATA_LINES_OE_N))
      else $error("address or data moved at write end");
   // one idle period with both strobes high already gives 10 ns spacing
   chk_cycle_gap: assert property (
      $rose(CHIP_SELECT_N) |-> (WRITE_ENABLE_N && OUTPUT_ENABLE_N)
      ##[0:1] REQ_READY)
      else $error("cycles too close");
   chk_write_walk: assert property (
      (REQ && REQ_READY && REQ_WRITE) |=> (!CHIP_SELECT_N
      && WORD_ADDRESS == $past(REQ_ADDR)
      && SHARED_DATA_LINES_O == $past(REQ_WDATA))
      ##1 !WRITE_ENABLE_N ##1 WRITE_ENABLE_N
      ##1 (CHIP_SELECT_N && REQ_READY))
      else $error("write sequence wrong");
   chk_read_walk: assert property (
      (REQ && REQ_READY && !REQ_WRITE) |=> (!CHIP_SELECT_N
      && WORD_ADDRESS == $past(REQ_ADDR)) ##1 !OUTPUT_ENABLE_N
      ##3 RD_VALID ##1 REQ_READY)
      else $error("read sequence wrong");
   cover property (REQ && REQ_READY && REQ_WRITE);
   cover property (RD_VALID);
   cover property ($rose(NRST));
endmodule : asrc_monitor
bind asrc_ctrl asrc_monitor #(.WP_CYCLES(WP_CYCLES),
   .ACC_CYCLES(ACC_CYCLES)) chk (.*);

/* sim/asrc_sram_model.sv */
`timescale 1ns/100ps
module asrc_sram_model (
   // memory pins
   input wire logic [18:0] addr,
   input wire logic cs_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [7:0] din,
   output logic [7:0] dout
);
   logic [7:0] mem [int];
   logic [7:0] last = 8'h00;
   wire drv = !cs_n && !oe_n && we_n;
   wire wend = cs_n | we_n;
   function automatic logic [7:0] rdf(input logic [18:0] a);
      return mem.exists(a) ? mem[a] : 8'h5a;
   endfunction : rdf
   // stored on the earliest strobe rise
   always @(posedge wend) if (!$isunknown(addr)) mem[addr] = din;
   // floated lines show the inverse, never a stale value
   always @(negedge drv) last = rdf(addr);
   assign #3 dout = drv ? rdf(addr) : ~last;
endmodule : asrc_sram_model

/* sim/testbench.sv */
`timescale 1ns/100ps
module testbench;
   import asrc_pkg::*;
   logic clk = 0, nrst = 0, req = 0, req_write = 0;
   logic req_ready, rd_valid, cs_n, we_n, oe_n, doe_n;
   logic [18:0] req_addr = '0, wa, a;
   logic [7:0] req_wdata = '0, rd_data, dout, mq, dq, d;
   logic [7:0] expq [$];
   logic [7:0] shadow [int];
   int n_checks = 0, failures = 0, seed = 40531;
   always #5 clk = ~clk;
   asrc_ctrl uut (.CLK(clk), .NRST(nrst), .REQ(req), .REQ_WRITE(req_write),
      .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_READY(req_ready),
      .RD_VALID(rd_valid), .RD_DATA(rd_data), .WORD_ADDRESS(wa),
      .CHIP_SELECT_N(cs_n), .WRITE_ENABLE_N(we_n), .OUTPUT_ENABLE_N(oe_n),
      .SHARED_DATA_LINES_I(dq), .SHARED_DATA_LINES_O(dout),
      .SHARED_DATA_LINES_OE_N(doe_n));
   asrc_sram_model mem (.addr(wa), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n),
      .din(dq), .dout(mq));
   assign dq = !doe_n ? dout : mq;
   task check(input string nm, input logic [18:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check
   task tally_and_finish;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : tally_and_finish
   task xfer(input logic w, input logic [18:0] ad, input logic [7:0] wd);
      @(posedge clk);
      req <= 1;
      req_write <= w;
      req_addr <= ad;
      req_wdata <= wd;
      if (w) shadow[ad] = wd;
      else expq.push_back(shadow.exists(ad) ? shadow[ad] : 8'h5a);
      do @(negedge clk); while (req_ready !== 1'b1);
      @(posedge clk);
      req <= 0;
   endtask : xfer
   // one compare per read pulse, oldest note first
   always @(negedge clk) if (rd_valid === 1'b1) begin
      check("rd_data", 19'(rd_data), 19'(expq.pop_front()));
   end
   initial begin
      #100000;
      failures++;
      tally_and_finish;
   end
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1;
      xfer(1, 19'h00000, 8'hff);
      xfer(1, 19'h7ffff, 8'h01);
      xfer(0, 19'h00000, 8'h00);
      xfer(0, 19'h7ffff, 8'h00);
      for (int i = 0; i < 16; i++) begin
         a = 19'($random(seed));
         d = 8'($random(seed));
         xfer(1, a, d);
         xfer(1, a, ~d);
         xfer(0, a, 8'h00);
         xfer(0, a ^ 19'h00001, 8'h00);
      end
      // reset in mid-write; that address is never read again
      xfer(1, 19'h12345, 8'h3c);
      @(posedge clk);
      nrst <= 0;
      @(negedge clk);
      check("cs_n", 19'(cs_n), 19'h1);
      check("doe_n", 19'(doe_n), 19'h1);
      @(posedge clk);
      nrst <= 1;
      xfer(0, 19'h7ffff, 8'h00);
      repeat (8) @(posedge clk);
      check("pending", 19'(expq.size()), 19'h0);
      tally_and_finish;
   end
endmodule : testbench
